// file: plt_pkg.sv
`default_nettype none
package plt_pkg;
  localparam logic [7:0] CMD_FRAME_START  = 8'h01;
  localparam logic [7:0] RESP_FRAME_START = 8'h81;
  localparam logic [7:0] FRAME_END        = 8'h03;
  localparam logic [7:0] LENGTH_HIGH      = 8'h00;
  localparam logic [7:0] CODE_TRANSIT     = 8'h72;
  localparam logic [7:0] CODE_LEVEL_REQ   = 8'h73;
  localparam logic [7:0] ERR_FLAG         = 8'h80;
  localparam logic [15:0] LEN_TRANSIT     = 16'h0003;
  localparam logic [15:0] LEN_LEVEL_REQ   = 16'h0001;
  localparam logic [7:0] LEN_LONG         = 8'h0a;
  localparam logic [7:0] LEN_SHORT        = 8'h02;
  // protection and authentication level codes
  localparam logic [7:0] PROT_LEVEL_TWO   = 8'h02;
  localparam logic [7:0] PROT_LEVEL_ONE   = 8'h03;
  localparam logic [7:0] PROT_LEVEL_ZERO  = 8'h04;
  localparam logic [7:0] AUTH_LEVEL_TWO   = 8'h02;
  localparam logic [7:0] AUTH_LEVEL_ONE   = 8'h03;
  localparam logic [7:0] AUTH_LEVEL_ZERO  = 8'h04;
  // status codes
  localparam logic [7:0] STS_OK           = 8'h00;
  localparam logic [7:0] STS_PACKET       = 8'hc1;
  localparam logic [7:0] STS_CHECKSUM     = 8'hc2;
  localparam logic [7:0] STS_ACCEPT       = 8'hc3;
  localparam logic [7:0] STS_PARAM        = 8'hc4;
  localparam logic [7:0] STS_PROTECT      = 8'hc5;
  localparam logic [7:0] STS_FLASH        = 8'hc6;
  localparam logic [7:0] STS_HARDWARE     = 8'hc7;
  localparam logic [31:0] UNUSED_WORD     = 32'hffffffff;
  localparam logic [3:0] LONG_LAST        = 4'he;
  localparam logic [3:0] SHORT_LAST       = 4'h6;
  localparam int         FIFO_WORDS       = 4;

  typedef struct packed {
    logic [7:0]  rcode;
    logic [7:0]  sts;
    logic [31:0] details;
    logic        short_f;
    logic [7:0]  lvl;
  } plt_resp_t;
endpackage
`default_nettype wire

// file: plt_transit_cmd.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module plt_fifo
  import plt_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_WORDS
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (wr_r - rd_r) != FULL;
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_r[AW-1:0]] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] transit frame: 01, 00, 03, 72, source, destination, check, 03
// [RULE2] level codes: 02 is level 2, 03 level 1, 04 level 0
// [RULE3] success answer: 81,00,0A,72,00, all-ones fields, check 8C, 03
// [RULE4] failure answer: 81,00,0A,F2, status, details, address, check, 03; the code sends FF in all four address bytes
// [RULE5] parsing starts only on start byte; other bytes dropped meanwhile
// [RULE6] missing end byte gives packet error
// [RULE7] bad check byte gives checksum error
// [RULE8] bad general or command length gives packet error
// [RULE9] any early error: no processing, nothing stored, back to waiting
// [RULE10] lifecycle state forbidding command gives acceptance error
// [RULE11] encrypted write without later reset gives acceptance error
// [RULE12] source level not present level gives parameter error
// [RULE13] unreachable destination level gives parameter error
// [RULE14] authentication level forbidding destination gives protection error
// [RULE15] flash fault gives flash error with flash status, then wait
// [RULE16] host should reread level after flash error
// [RULE17] invalid level after change: hardware error, then unresponsive
// [RULE18] good transition sends OK and returns to waiting
// [RULE19] only highest-priority error is reported, in fixed order
// [RULE20] auth table: 0->1 needs auth 2/1; into level 2 needs auth 2
// [RULE21] level request 73 answers 81,00,02,73, level code, check, 03
// [RULE22] check byte makes low byte of summed frame bytes zero
module plt_transit_cmd
  import plt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  input  wire logic        lifecycle_ok,
  input  wire logic        enc_write_pending,
  input  wire logic [7:0]  auth_level,
  input  wire logic [7:0]  prot_level,
  output logic             flash_req,
  output logic [7:0]       flash_dest,
  input  wire logic        flash_done,
  input  wire logic        flash_err,
  input  wire logic [31:0] flash_status,
  output logic             halted
);
  typedef enum logic [3:0] {
    S_WAIT, S_LENH, S_LENL, S_BODY, S_SUM, S_END,
    S_EVAL, S_FLASH, S_CHECK, S_SEND, S_HALT
  } plt_state_t;

  function automatic plt_resp_t mk_resp(input logic [7:0]  rc,
                                        input logic [7:0]  sts,
                                        input logic [31:0] det);
    return '{rcode: rc, sts: sts, details: det, short_f: 1'b0,
             lvl: 8'h00};
  endfunction

  function automatic logic [7:0] resp_byte(input logic [3:0] i,
                                           input plt_resp_t r,
                                           input logic [7:0] s);
    logic [3:0] last;
    last = r.short_f ? SHORT_LAST : LONG_LAST;
    if (i == 4'h0) return RESP_FRAME_START;
    if (i == last) return FRAME_END;
    if (i == last - 4'h1) return 8'h00 - s;
    case (i)
      4'h1: return LENGTH_HIGH;
      4'h2: return r.short_f ? LEN_SHORT : LEN_LONG;
      4'h3: return r.rcode;
      4'h4: return r.short_f ? r.lvl : r.sts;
      4'h5: return r.details[31:24];
      4'h6: return r.details[23:16];
      4'h7: return r.details[15:8];
      4'h8: return r.details[7:0];
      default: return UNUSED_WORD[7:0];
    endcase
  endfunction

  plt_state_t  state_r;
  plt_resp_t   resp_r;
  logic [15:0] len_r;
  logic [15:0] cnt_r;
  logic [7:0]  cmd_r;
  logic [7:0]  spl_r;
  logic [7:0]  dpl_r;
  logic [7:0]  sum_r;
  logic [7:0]  tx_sum_r;
  logic [3:0]  idx_r;
  logic        sum_bad_r;
  logic        end_bad_r;
  logic        halt_after_r;
  logic        flash_req_r;
  logic [7:0]  flash_dest_r;
  logic        fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // receive side decode
  assign rx_ready = state_r inside {S_WAIT, S_LENH, S_LENL, S_BODY, S_SUM,
                                    S_END, S_HALT};
  wire        rx_take  = rx_valid && rx_ready;
  wire [7:0]  sum_add  = sum_r + rx_data;
  wire [15:0] cnt_inc  = cnt_r + 16'h0001;
  wire        body_end = cnt_inc == len_r;

  ////////////////////////////////////////////////////////////////////////////
  // evaluation in priority order
  wire is_transit  = cmd_r == CODE_TRANSIT;
  wire is_lreq     = cmd_r == CODE_LEVEL_REQ;
  wire fmt_bad     = len_r == 16'h0000 || len_r[15:8] != 8'h00; // RULE8
  wire cmd_len_bad = !(is_transit && len_r == LEN_TRANSIT) &&
                     !(is_lreq && len_r == LEN_LEVEL_REQ);   // RULE1 RULE8
  wire life_bad    = is_transit && !lifecycle_ok;            // RULE10
  wire acc_bad     = life_bad || enc_write_pending;          // RULE11
  wire reach_ok    = (prot_level == PROT_LEVEL_ZERO &&
                      (dpl_r == PROT_LEVEL_ONE ||
                       dpl_r == PROT_LEVEL_TWO)) ||
                     (prot_level == PROT_LEVEL_ONE &&
                      (dpl_r == PROT_LEVEL_ZERO ||
                       dpl_r == PROT_LEVEL_TWO));           // RULE2 RULE13
  wire src_bad     = spl_r != prot_level;                    // RULE12
  wire par_bad     = is_transit && (src_bad || !reach_ok);
  wire auth_ok     = (dpl_r == PROT_LEVEL_TWO) ?
                     auth_level == AUTH_LEVEL_TWO :
                     auth_level != AUTH_LEVEL_ZERO;          // RULE20
  wire prot_bad    = is_transit && !auth_ok;                 // RULE14
  wire [7:0] eval_sts =
    end_bad_r                ? STS_PACKET   :                // RULE6
    sum_bad_r                ? STS_CHECKSUM :                // RULE7
    (fmt_bad || cmd_len_bad) ? STS_PACKET   :
    acc_bad                  ? STS_ACCEPT   :
    par_bad                  ? STS_PARAM    :
    prot_bad                 ? STS_PROTECT  : STS_OK;        // RULE19
  wire eval_fail  = eval_sts != STS_OK;
  wire lvl_valid  = prot_level == PROT_LEVEL_ZERO ||
                    prot_level == PROT_LEVEL_ONE ||
                    prot_level == PROT_LEVEL_TWO;
  wire [7:0] err_code = cmd_r | ERR_FLAG;                     // RULE4

  ////////////////////////////////////////////////////////////////////////////
  // transmit side decode
  wire [3:0] last_idx  = resp_r.short_f ? SHORT_LAST : LONG_LAST;
  wire       send_push = state_r == S_SEND && fifo_in_ready;
  wire [7:0] send_byte = resp_byte(idx_r, resp_r, tx_sum_r); // RULE22
  wire       send_done = send_push && idx_r == last_idx;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r      <= S_WAIT;
      resp_r       <= '0;
      len_r        <= 16'h0000;
      cnt_r        <= 16'h0000;
      cmd_r        <= 8'h00;
      spl_r        <= 8'h00;
      dpl_r        <= 8'h00;
      sum_r        <= 8'h00;
      sum_bad_r    <= 1'b0;
      end_bad_r    <= 1'b0;
      halt_after_r <= 1'b0;
      flash_req_r  <= 1'b0;
      flash_dest_r <= 8'h00;
    end else begin
      flash_req_r <= 1'b0;
      case (state_r)
        S_WAIT: if (rx_take && rx_data == CMD_FRAME_START) begin // RULE5
          state_r <= S_LENH;
          sum_r   <= 8'h00;
          cnt_r   <= 16'h0000;
          cmd_r   <= 8'h00;
          spl_r   <= 8'h00;
          dpl_r   <= 8'h00;
        end
        S_LENH: if (rx_take) begin
          len_r[15:8] <= rx_data;
          sum_r       <= sum_add;
          state_r     <= S_LENL;
        end
        S_LENL: if (rx_take) begin
          len_r[7:0] <= rx_data;
          sum_r      <= sum_add;
          state_r    <= ({len_r[15:8], rx_data} == 16'h0000) ? S_SUM : S_BODY;
        end
        S_BODY: if (rx_take) begin
          if (cnt_r == 16'h0000) cmd_r <= rx_data;
          if (cnt_r == 16'h0001) spl_r <= rx_data;
          if (cnt_r == 16'h0002) dpl_r <= rx_data;
          cnt_r <= cnt_inc;
          sum_r <= sum_add;
          if (body_end) state_r <= S_SUM;
        end
        S_SUM: if (rx_take) begin
          sum_bad_r <= sum_add != 8'h00;                          // RULE22
          state_r   <= S_END;
        end
        S_END: if (rx_take) begin
          end_bad_r <= rx_data != FRAME_END;
          state_r   <= S_EVAL;
        end
        S_EVAL: begin
          state_r <= S_SEND;
          if (eval_fail) begin
            resp_r <= mk_resp(err_code, eval_sts, UNUSED_WORD);   // RULE9
          end else if (is_lreq) begin
            resp_r <= '{rcode: CODE_LEVEL_REQ, sts: STS_OK,
                        details: UNUSED_WORD, short_f: 1'b1,
                        lvl: prot_level};                         // RULE21
          end else begin
            flash_req_r  <= 1'b1;
            flash_dest_r <= dpl_r;
            state_r      <= S_FLASH;
          end
        end
        S_FLASH: if (flash_done) begin
          if (flash_err) begin
            resp_r  <= mk_resp(err_code, STS_FLASH, flash_status); // RULE15
            state_r <= S_SEND;
          end else begin
            state_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          state_r <= S_SEND;
          if (!lvl_valid) begin
            resp_r       <= mk_resp(err_code, STS_HARDWARE, UNUSED_WORD);
            halt_after_r <= 1'b1;                                 // RULE17
          end else begin
            resp_r <= mk_resp(CODE_TRANSIT, STS_OK, UNUSED_WORD); // RULE18
          end
        end
        S_SEND: if (send_done) begin
          state_r <= halt_after_r ? S_HALT : S_WAIT;
        end
        S_HALT: state_r <= S_HALT;
        default: state_r <= S_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      idx_r    <= 4'h0;
      tx_sum_r <= 8'h00;
    end else if (send_push) begin
      idx_r    <= send_done ? 4'h0 : idx_r + 4'h1;
      tx_sum_r <= (idx_r == 4'h0) ? 8'h00 : tx_sum_r + send_byte; // RULE3
    end
  end

  assign flash_req  = flash_req_r;
  assign flash_dest = flash_dest_r;
  assign halted     = state_r == S_HALT;

  plt_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (state_r == S_SEND),
    .in_data   (send_byte),
    .in_ready  (fifo_in_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_wait_drop_byte: assert property (state_r == S_WAIT && rx_take && // RULE5
      rx_data != CMD_FRAME_START |=> state_r == S_WAIT)
    else $error("non-start byte left wait state");
  a_end_first: assert property (state_r == S_EVAL && end_bad_r // RULE6
      |=> state_r == S_SEND && resp_r.sts == STS_PACKET)
    else $error("missing end byte not reported first");
  a_sum_second: assert property (state_r == S_EVAL && !end_bad_r && // RULE7
      sum_bad_r |=> resp_r.sts == STS_CHECKSUM)
    else $error("checksum error not reported");
  a_error_no_flash: assert property (state_r == S_EVAL && eval_fail // RULE9
      |=> !flash_req ##1 !flash_req)
    else $error("flash touched after early error");
  a_accept_order: assert property (state_r == S_EVAL && // RULE10
      is_transit && !lifecycle_ok && !end_bad_r && !sum_bad_r &&
      len_r == LEN_TRANSIT |=> resp_r.sts == STS_ACCEPT)
    else $error("lifecycle refusal not reported as acceptance error");
  a_flash_status: assert property (state_r == S_FLASH && flash_done && // RULE15
      flash_err |=> resp_r.details == $past(flash_status) &&
      resp_r.sts == STS_FLASH)
    else $error("flash status not carried");
  a_halt_sticks: assert property (halted |=> halted [*8]) // RULE17
    else $error("left unresponsive state");
  a_ok_check_byte: assert property (send_push && idx_r == 4'hd && // RULE3
      resp_r.rcode == CODE_TRANSIT && resp_r.sts == STS_OK
      |-> send_byte == 8'h8c)
    else $error("ok answer check byte wrong");
  a_resp_start: assert property (send_push && idx_r == 4'h0 // RULE4
      |-> send_byte == RESP_FRAME_START)
    else $error("answer does not open with start byte");

  c_transit_ok: cover property (send_done && resp_r.sts == STS_OK &&
      !resp_r.short_f);
  c_level_req: cover property (send_done && resp_r.short_f);
  c_flash_fail: cover property (send_done && resp_r.sts == STS_FLASH);
  c_fifo_full: cover property (state_r == S_SEND && !fifo_in_ready);
endmodule
`default_nettype wire

// file: plt_host_model.sv
`default_nettype none
module plt_host_model
  import plt_pkg::*;
(
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_q[$];
  bit         stall = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
////////////////////////////////////////////////////////////////////////////
  // answer collection; sink stalls at random when asked
  always @(posedge clk) if (tx_valid && tx_ready) got_q.push_back(tx_data);
  always @(negedge clk) tx_ready <= stall ? ($urandom % 4 == 0) : 1'b1;
////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b, output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data  = b;
    do begin
      @(posedge clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 200);
    ok = (rx_ready === 1'b1);
  endtask
  // length, body, check byte, end byte; cadj spoils the check byte
  task automatic send_frame(input logic [7:0] body[$],
                            input logic [7:0] cadj, endb, output bit ok);
    logic [7:0] fr[$];
    logic [7:0] s;
    bit         o;
    fr = {CMD_FRAME_START, LENGTH_HIGH, 8'(body.size())};
    foreach (body[i]) fr.push_back(body[i]);
    s = 8'h00;
    for (int i = 1; i < fr.size(); i++) s += fr[i];
    fr.push_back(8'h00 - s + cadj);
    fr.push_back(endb);
    ok = 1'b1;
    foreach (fr[i]) begin
      send(fr[i], o);
      ok &= o;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule
`default_nettype wire

// file: test_protection_level_transit_cmd.sv
`default_nettype none
module test_protection_level_transit_cmd
  import plt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] plt_bytes_t[$];
  logic        clk, reset, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data, auth_level, prot_level, flash_dest;
  logic        lifecycle_ok, enc_write_pending, flash_req, flash_err;
  logic        halted;
  logic        flash_done = 1'b0;
  logic [31:0] flash_status;
  logic [7:0]  fl_next, src, dst, sts;
  logic [7:0]  codes[3] = '{PROT_LEVEL_TWO, PROT_LEVEL_ONE, PROT_LEVEL_ZERO};
  int          errors, checks_done, fl_wait, fl_reqs, reqs;
  bit          ok;
  plt_bytes_t  want;

  plt_transit_cmd uut (.clk(clk), .reset(reset), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .lifecycle_ok(lifecycle_ok),
    .enc_write_pending(enc_write_pending), .auth_level(auth_level),
    .prot_level(prot_level), .flash_req(flash_req),
    .flash_dest(flash_dest), .flash_done(flash_done),
    .flash_err(flash_err), .flash_status(flash_status), .halted(halted));
  plt_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  always #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////////
  // flash side: done three cycles after the request, level then moves unless flash_err is set
  always @(posedge clk) if (flash_req === 1'b1) begin
    fl_wait = 3;
    fl_reqs++;
  end
  always @(negedge clk) begin
    flash_done = 1'b0;
    if (fl_wait == 1) begin
      flash_done = 1'b1;
      if (!flash_err) prot_level = fl_next;
    end
    if (fl_wait > 0) fl_wait--;
  end
////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic plt_bytes_t mk_resp(input logic [7:0] rc,
                                         input plt_bytes_t pl);
    plt_bytes_t f;
    logic [7:0] s;
    f = {RESP_FRAME_START, LENGTH_HIGH, 8'(pl.size() + 1), rc};
    foreach (pl[i]) f.push_back(pl[i]);
    s = 8'h00;
    for (int i = 1; i < f.size(); i++) s += f[i];
    f.push_back(8'h00 - s);
    f.push_back(FRAME_END);
    return f;
  endfunction
  function automatic plt_bytes_t long_pl(input logic [7:0] st,
                                         input logic [31:0] d);
    return {st, d[31:24], d[23:16], d[15:8], d[7:0],
            8'hff, 8'hff, 8'hff, 8'hff};
  endfunction
  function automatic logic [7:0] calc_sts(input logic [7:0] p, s, d, a);
    if (s != p) return STS_PARAM;
    if (!((p == PROT_LEVEL_ZERO && (d == PROT_LEVEL_ONE ||
           d == PROT_LEVEL_TWO)) || (p == PROT_LEVEL_ONE &&
          (d == PROT_LEVEL_ZERO || d == PROT_LEVEL_TWO)))) return STS_PARAM;
    if (a == AUTH_LEVEL_ZERO) return STS_PROTECT;
    if (d == PROT_LEVEL_TWO && a != AUTH_LEVEL_TWO) return STS_PROTECT;
    return STS_OK;
  endfunction
  task automatic cmd(input plt_bytes_t body, input logic [7:0] cadj, endb);
    host.send_frame(body, cadj, endb, ok);
    if (!ok) begin
      check("rx handshake", 0, 1);
      stop_test();
    end
  endtask
  task automatic expect_resp(input string what, input plt_bytes_t exp);
    int n;
    n = 0;
    while (host.got_q.size() < exp.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (host.got_q.size() < exp.size()) begin
      check("answer bytes", host.got_q.size(), exp.size());
      stop_test();
    end
    repeat (4) @(posedge clk);
    check("answer length", host.got_q.size(), exp.size());
    foreach (exp[i]) check(what, host.got_q[i], exp[i]);
    host.got_q.delete();
    $display("test %s done", what);
  endtask
  task automatic corner(input string what, input plt_bytes_t body,
                        input logic [7:0] cadj, endb,
                        input logic lc, enc, input logic [7:0] st);
    @(negedge clk);
    lifecycle_ok      = lc;
    enc_write_pending = enc;
    reqs              = fl_reqs;
    cmd(body, cadj, endb);
    expect_resp(what, mk_resp(body[0] | ERR_FLAG, long_pl(st, UNUSED_WORD)));
    check("flash requests", fl_reqs - reqs, 0);
  endtask
////////////////////////////////////////////////////////////////////////////
  initial begin
    clk               = 1'b0;
    reset             = 1'b1;
    lifecycle_ok      = 1'b1;
    enc_write_pending = 1'b0;
    auth_level        = AUTH_LEVEL_ONE;
    prot_level        = PROT_LEVEL_ZERO;
    flash_err         = 1'b0;
    flash_status      = 32'h0;
    fl_next           = 8'h00;
    errors            = 0;
    checks_done       = 0;
    fl_wait           = 0;
    fl_reqs           = 0;
    reqs = $urandom(82);
    repeat (12) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    check("rx_ready", rx_ready, 1);
    check("tx_valid", tx_valid, 0);
    check("halted", halted, 0);
    // noise before the start byte is dropped
    for (int i = 0; i < 5; i++) host.send(8'($urandom % 254 + 2), ok);
    cmd({CODE_LEVEL_REQ}, 8'h00, FRAME_END);
    want = mk_resp(CODE_LEVEL_REQ, {prot_level});
    expect_resp("level request", want);
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      host.stall = i[0];
      prot_level = codes[$urandom % 3];
      auth_level = codes[$urandom % 3];
      src = ($urandom % 4 != 0) ? prot_level : codes[$urandom % 3];
      dst = ($urandom % 8 == 0) ? 8'h05 : codes[$urandom % 3];
      sts = calc_sts(prot_level, src, dst, auth_level);
      fl_next = dst;
      reqs = fl_reqs;
      cmd({CODE_TRANSIT, src, dst}, 8'h00, FRAME_END);
      if (sts == STS_OK) begin
        want = mk_resp(CODE_TRANSIT, long_pl(STS_OK, UNUSED_WORD));
        expect_resp("transit ok", want);
        check("flash dest", flash_dest, dst);
      end else begin
        want = mk_resp(CODE_TRANSIT | ERR_FLAG, long_pl(sts, UNUSED_WORD));
        expect_resp("refused", want);
      end
      check("flash requests", fl_reqs - reqs, sts == STS_OK);
    end
    @(negedge clk);
    host.stall = 1'b0;
    prot_level = PROT_LEVEL_ZERO;
    auth_level = AUTH_LEVEL_ONE;
    corner("missing end", {CODE_TRANSIT, 8'h04, 8'h03}, 8'h01, 8'h55,
           1'b0, 1'b1, STS_PACKET);
    corner("bad check", {CODE_TRANSIT, 8'h04, 8'h03}, 8'h01, FRAME_END,
           1'b0, 1'b0, STS_CHECKSUM);
    corner("bad length", {CODE_TRANSIT, 8'h04}, 8'h00, FRAME_END,
           1'b1, 1'b0, STS_PACKET);
    corner("unknown cmd", {8'h55}, 8'h00, FRAME_END,
           1'b1, 1'b0, STS_PACKET);
    corner("lifecycle", {CODE_TRANSIT, 8'h03, 8'h03}, 8'h00, FRAME_END,
           1'b0, 1'b0, STS_ACCEPT);
    corner("enc write", {CODE_TRANSIT, 8'h04, 8'h03}, 8'h00, FRAME_END,
           1'b1, 1'b1, STS_ACCEPT);
    corner("enc level", {CODE_LEVEL_REQ}, 8'h00, FRAME_END,
           1'b1, 1'b1, STS_ACCEPT);
    @(negedge clk);
    enc_write_pending = 1'b0;
    flash_err = 1'b1;
    flash_status = $urandom;
    fl_next = PROT_LEVEL_ONE;
    cmd({CODE_TRANSIT, 8'h04, 8'h03}, 8'h00, FRAME_END);
    want = mk_resp(CODE_TRANSIT | ERR_FLAG, long_pl(STS_FLASH, flash_status));
    expect_resp("flash fault", want);
    @(negedge clk) flash_err = 1'b0;
    // level reread after the fault finds it unchanged
    cmd({CODE_LEVEL_REQ}, 8'h00, FRAME_END);
    want = mk_resp(CODE_LEVEL_REQ, {PROT_LEVEL_ZERO});
    expect_resp("reread", want);
    fl_next = 8'h07;
    cmd({CODE_TRANSIT, 8'h04, 8'h03}, 8'h00, FRAME_END);
    want = mk_resp(CODE_TRANSIT | ERR_FLAG,
                   long_pl(STS_HARDWARE, UNUSED_WORD));
    expect_resp("bad level", want);
    cmd({CODE_LEVEL_REQ}, 8'h00, FRAME_END);
    repeat (40) @(posedge clk);
    check("bytes after halt", host.got_q.size(), 0);
    check("halted", halted, 1);
    // a fresh reset brings the handler back
    @(negedge clk);
    reset      = 1'b1;
    prot_level = PROT_LEVEL_ONE;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check("halted", halted, 0);
    check("rx_ready", rx_ready, 1);
    check("tx_valid", tx_valid, 0);
    cmd({CODE_LEVEL_REQ}, 8'h00, FRAME_END);
    want = mk_resp(CODE_LEVEL_REQ, {PROT_LEVEL_ONE});
    expect_resp("after reset", want);
    stop_test();
  end
endmodule
`default_nettype wire
